// [src/motion_led_dimmer.sv]
// motion triggered led string dimmer with console, pot or light control
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - a motion report switches the led string on by enabling pwm
// - string goes off after ten seconds without motion; motion restarts it
// - every requested duty is clamped between 15 and 95 percent
// - console command 8 sets duty; operator sends only 0x0f to 0x5f
// - command 2 returns a ram byte, command 3 overwrites one
// - command 4 toggles event reports, 5 clears log, 6 dumps log
// - command 7 reports engine registers, command 1 resends the menu
// - console mode: pin two pwm, pins four and five serial, zero/one unused
// - potentiometer mode disables the command interpreter and serial port
// - potentiometer mode takes duty from analog channel one on pin four
// - rising input voltage maps to exponentially rising duty
// - light mode takes duty from analog channel three, powers sensor on five
// - light mode polarity pin zero picks falling or rising duty
// - pin two always carries pwm, pin three stays the motion input
// - motion is ignored one second after each led enable or disable
module motion_led_dimmer
  import dimmer_pkg::*;
#(
  parameter mode_e MODE = MODE_CONSOLE,
  parameter longint unsigned OFF_CYC = LED_OFF_CYC,
  parameter longint unsigned BLANK_CYCLES = BLANK_CYC,
  parameter int unsigned UART_DIV = BAUD_DIV,
  parameter int unsigned PWM_PRESCALE = PWM_DIV,
  parameter int unsigned LOG_DEPTH = 8,
  parameter int unsigned RAM_DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_motion,
  input wire logic [7:0] i_analog_channel_one,
  input wire logic i_analog_channel_one_vld,
  input wire logic [7:0] i_analog_channel_three,
  input wire logic i_analog_channel_three_vld,
  input wire logic i_port_pin_zero,
  input wire logic i_port_pin_four,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_port_pin_two,
  output logic o_port_pin_five,
  output logic o_port_pin_five_oe,
  output logic o_led_on
);
  localparam int LW = $clog2(LOG_DEPTH);
  localparam int RW = $clog2(RAM_DEPTH);

  typedef struct packed {
    logic led_on;
    logic [31:0] off_cnt;
    logic [31:0] blank_cnt;
    logic [7:0] duty;
    logic report_en;
    logic evt_pend;
    logic [7:0] evt_cnt;
    logic [LOG_DEPTH-1:0][7:0] log_mem;
    logic [LW-1:0] log_wp;
    logic [LW:0] log_n;
    logic [RAM_DEPTH-1:0][7:0] ram;
    cmd_e cst;
    logic [7:0] op;
    logic [7:0] addr;
    reply_e kind;
    logic [7:0] idx;
    logic [7:0] len;
    logic tx_vld;
    logic [7:0] tx_byte;
    logic [7:0] rdata;
    logic [2:0] rx_s;
    logic rx_f;
    logic [2:0] pol_s;
    logic pol_f;
    logic pin5;
    logic pin5_oe;
  } top_s;

  top_s s_r;
  top_s s_nxt;
  logic rx_vld;
  logic [7:0] rx_data;
  logic tx_rdy;
  logic tx_line;

  function automatic logic [7:0] clamp_duty(input logic [7:0] d);
    if (d < DUTY_LOWER_CLAMP) begin
      return DUTY_LOWER_CLAMP;
    end else if (d > DUTY_UPPER_CLAMP) begin
      return DUTY_UPPER_CLAMP;
    end
    return d;
  endfunction : clamp_duty

  // mantissa doubles every eighth of the input range, so low steps are fine
  function automatic logic [7:0] exp_duty(input logic [7:0] x);
    logic [13:0] e;
    logic [19:0] p;
    e = 14'({1'b1, x[4:0]}) << x[7:5];
    p = 20'(e) * 20'd81;
    return 8'(p[19:13]) + DUTY_LOWER_CLAMP;
  endfunction : exp_duty

  function automatic logic [7:0] status_byte(input top_s s);
    return {5'h00, s.blank_cnt != 32'h0, s.report_en, s.led_on};
  endfunction : status_byte

  always_comb begin
    logic accept;
    logic [LW-1:0] li;
    logic [7:0] rep;
    accept = 1'b0;
    li = '0;
    rep = '0;
    s_nxt = s_r;
    s_nxt.rdata = '0;

    // three stage sync; a level counts once stages two and three agree
    s_nxt.rx_s = {s_r.rx_s[1:0], i_port_pin_four};
    if (s_r.rx_s[1] == s_r.rx_s[2]) begin
      s_nxt.rx_f = s_r.rx_s[2];
    end
    s_nxt.pol_s = {s_r.pol_s[1:0], i_port_pin_zero};
    if (s_r.pol_s[1] == s_r.pol_s[2]) begin
      s_nxt.pol_f = s_r.pol_s[2];
    end

    if (s_r.tx_vld && tx_rdy) begin
      s_nxt.tx_vld = 1'b0;
    end

    // command interpreter, only reachable in console mode
    case (s_r.cst)
      C_IDLE: begin
        if (rx_vld) begin
          s_nxt.op = rx_data;
          s_nxt.idx = '0;
          case (rx_data)
            CMD_MENU: begin
              s_nxt.kind = K_MENU;
              s_nxt.len = MENU_LEN;
              s_nxt.cst = C_SEND;
            end
            CMD_RD_RAM, CMD_WR_RAM: begin
              s_nxt.cst = C_ADDR;
            end
            CMD_EVT_TOGGLE: begin
              s_nxt.report_en = !s_r.report_en;
            end
            CMD_LOG_CLEAR: begin
              s_nxt.evt_cnt = '0;
              s_nxt.log_wp = '0;
              s_nxt.log_n = '0;
            end
            CMD_LOG_DUMP: begin
              s_nxt.kind = K_LOG;
              s_nxt.len = 8'(s_r.log_n);
              s_nxt.cst = C_SEND;
            end
            CMD_API: begin
              s_nxt.kind = K_API;
              s_nxt.len = API_LEN;
              s_nxt.cst = C_SEND;
            end
            CMD_DUTY: begin
              s_nxt.cst = C_DUTY;
            end
            default: begin
              s_nxt.cst = C_IDLE;
            end
          endcase
        end else if (s_r.evt_pend && !s_r.tx_vld) begin
          s_nxt.evt_pend = 1'b0;
          s_nxt.tx_vld = 1'b1;
          s_nxt.tx_byte = EVT_TAG;
        end
      end
      C_ADDR: begin
        if (rx_vld) begin
          s_nxt.addr = rx_data;
          if (s_r.op == CMD_RD_RAM) begin
            s_nxt.kind = K_RAM;
            s_nxt.len = 8'h01;
            s_nxt.cst = C_SEND;
          end else begin
            s_nxt.cst = C_DATA;
          end
        end
      end
      C_DATA: begin
        if (rx_vld) begin
          s_nxt.ram[RW'(s_r.addr)] = rx_data;
          s_nxt.cst = C_IDLE;
        end
      end
      C_DUTY: begin
        if (rx_vld) begin
          s_nxt.duty = clamp_duty(rx_data);
          s_nxt.cst = C_IDLE;
        end
      end
      C_SEND: begin
        if (!s_r.tx_vld) begin
          if (s_r.idx == s_r.len) begin
            s_nxt.cst = C_IDLE;
          end else begin
            // oldest entry first once the log has wrapped
            li = s_r.log_n[LW] ? s_r.log_wp + LW'(s_r.idx) : LW'(s_r.idx);
            case (s_r.kind)
              K_MENU: rep = CMD_MENU + s_r.idx;
              K_RAM: rep = s_r.ram[RW'(s_r.addr)];
              K_LOG: rep = s_r.log_mem[li];
              default: begin
                case (s_r.idx)
                  8'h00: rep = s_r.duty;
                  8'h01: rep = status_byte(s_r);
                  default: rep = s_r.evt_cnt;
                endcase
              end
            endcase
            s_nxt.tx_byte = rep;
            s_nxt.tx_vld = 1'b1;
            s_nxt.idx = s_r.idx + 8'h01;
          end
        end
      end
      default: begin
        s_nxt.cst = C_IDLE;
      end
    endcase

    // duty from the analog source of this build
    if (MODE == MODE_POT && i_analog_channel_one_vld) begin
      s_nxt.duty = clamp_duty(exp_duty(i_analog_channel_one));
    end
    if (MODE == MODE_ALS && i_analog_channel_three_vld) begin
      // pin zero high is the shunt on 1-2: brighter room, dimmer string
      s_nxt.duty = clamp_duty(exp_duty(s_r.pol_f ? ~i_analog_channel_three
                                       : i_analog_channel_three));
    end

    // register port
    if (i_wr) begin
      case (i_addr)
        REG_DUTY: s_nxt.duty = clamp_duty(i_wdata);
        REG_CTRL: s_nxt.report_en = i_wdata[0];
        default: s_nxt.duty = s_nxt.duty;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        REG_DUTY: s_nxt.rdata = s_r.duty;
        REG_STATUS: s_nxt.rdata = status_byte(s_r);
        REG_CTRL: s_nxt.rdata = {7'h00, s_r.report_en};
        REG_EVT_CNT: s_nxt.rdata = s_r.evt_cnt;
        default: s_nxt.rdata = '0;
      endcase
    end

    // motion timing; pin three feeds the engine that raises i_motion
    if (s_r.blank_cnt != 32'h0) begin
      s_nxt.blank_cnt = s_r.blank_cnt - 32'h1;
    end
    accept = i_motion && (s_r.blank_cnt == 32'h0);
    if (accept) begin
      s_nxt.off_cnt = 32'(OFF_CYC);
      if (!s_r.led_on) begin
        s_nxt.led_on = 1'b1;
        s_nxt.blank_cnt = 32'(BLANK_CYCLES);
      end
      // logging after the clear above, so an event in that cycle survives
      s_nxt.evt_cnt = s_nxt.evt_cnt + 8'h01;
      s_nxt.log_mem[s_nxt.log_wp] = s_nxt.evt_cnt;
      s_nxt.log_wp = s_nxt.log_wp + LW'(1);
      if (s_nxt.log_n != (LW + 1)'(LOG_DEPTH)) begin
        s_nxt.log_n = s_nxt.log_n + (LW + 1)'(1);
      end
      if (s_r.report_en && MODE == MODE_CONSOLE) begin
        s_nxt.evt_pend = 1'b1;
      end
    end else if (s_r.led_on) begin
      s_nxt.off_cnt = s_r.off_cnt - 32'h1;
      if (s_r.off_cnt == 32'h1) begin
        s_nxt.led_on = 1'b0;
        s_nxt.blank_cnt = 32'(BLANK_CYCLES);
      end
    end

    // pin five: serial out in console, sensor supply in light mode
    case (MODE)
      MODE_CONSOLE: begin
        s_nxt.pin5 = tx_line;
        s_nxt.pin5_oe = 1'b1;
      end
      MODE_ALS: begin
        s_nxt.pin5 = 1'b1;
        s_nxt.pin5_oe = 1'b1;
      end
      default: begin
        s_nxt.pin5 = 1'b0;
        s_nxt.pin5_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.duty <= DUTY_LOWER_CLAMP;
      s_r.report_en <= REPORT_EN_RST;
      s_r.rx_s <= 3'h7;
      s_r.rx_f <= 1'b1;
      s_r.cst <= C_IDLE;
      s_r.kind <= K_MENU;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  dimmer_uart #(
    .DIV(UART_DIV)
  ) u_uart (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_en(MODE == MODE_CONSOLE),
    .i_rx(s_r.rx_f),
    .o_rx_vld(rx_vld),
    .o_rx_data(rx_data),
    .i_tx_vld(s_r.tx_vld),
    .i_tx_data(s_r.tx_byte),
    .o_tx_rdy(tx_rdy),
    .o_tx(tx_line)
  );

  dimmer_pwm #(
    .DIV(PWM_PRESCALE)
  ) u_pwm (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_en(s_r.led_on),
    .i_duty(s_r.duty),
    .o_pwm(o_port_pin_two)
  );

  assign o_rdata = s_r.rdata;
  assign o_port_pin_five = s_r.pin5;
  assign o_port_pin_five_oe = s_r.pin5_oe;
  assign o_led_on = s_r.led_on;
endmodule : motion_led_dimmer
`default_nettype wire

// [common/dimmer_pkg.sv]
// shared constants and types of the motion triggered led dimmer
package dimmer_pkg;
  typedef enum logic [1:0] {
    MODE_CONSOLE = 2'h0,
    MODE_POT = 2'h1,
    MODE_ALS = 2'h2
  } mode_e;

  typedef enum logic [2:0] {
    C_IDLE = 3'h0,
    C_ADDR = 3'h1,
    C_DATA = 3'h2,
    C_DUTY = 3'h3,
    C_SEND = 3'h4
  } cmd_e;

  typedef enum logic [1:0] {
    K_MENU = 2'h0,
    K_RAM = 2'h1,
    K_LOG = 2'h2,
    K_API = 2'h3
  } reply_e;

  localparam longint unsigned CLK_HZ = 64'd250_000_000;
  localparam longint unsigned LED_OFF_S = 64'd10;
  localparam longint unsigned BLANK_S = 64'd1;
  localparam longint unsigned LED_OFF_CYC = LED_OFF_S * CLK_HZ;
  localparam longint unsigned BLANK_CYC = BLANK_S * CLK_HZ;
  localparam longint unsigned BAUD = 64'd115200;
  localparam int unsigned BAUD_DIV = int'(CLK_HZ / BAUD);
  localparam int unsigned PWM_DIV = 25;

  // duty is held in percent
  localparam logic [7:0] DUTY_LOWER_CLAMP = 8'h0f;
  localparam logic [7:0] DUTY_UPPER_CLAMP = 8'h5f;
  localparam logic [7:0] PWM_PERIOD = 8'h64;

  localparam logic [7:0] CMD_MENU = 8'h01;
  localparam logic [7:0] CMD_RD_RAM = 8'h02;
  localparam logic [7:0] CMD_WR_RAM = 8'h03;
  localparam logic [7:0] CMD_EVT_TOGGLE = 8'h04;
  localparam logic [7:0] CMD_LOG_CLEAR = 8'h05;
  localparam logic [7:0] CMD_LOG_DUMP = 8'h06;
  localparam logic [7:0] CMD_API = 8'h07;
  localparam logic [7:0] CMD_DUTY = 8'h08;
  localparam logic [7:0] MENU_LEN = 8'h08;
  localparam logic [7:0] API_LEN = 8'h03;
  localparam logic [7:0] EVT_TAG = 8'h4d;

  localparam logic [3:0] REG_DUTY = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [3:0] REG_EVT_CNT = 4'hc;
  localparam logic REPORT_EN_RST = 1'b0;
endpackage : dimmer_pkg

// [src/dimmer_pwm.sv]
// pwm generator for led brightness
`timescale 1ns/100ps
`default_nettype none
module dimmer_pwm
  import dimmer_pkg::*;
#(
  parameter int unsigned DIV = PWM_DIV
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_en,
  input wire logic [7:0] i_duty,
  output logic o_pwm
);
  typedef struct packed {
    logic [15:0] pre;
    logic [7:0] pos;
    logic out;
  } pwm_s;

  pwm_s s_r;
  pwm_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (s_r.pre == 16'(DIV - 1)) begin
      s_nxt.pre = '0;
      s_nxt.pos = (s_r.pos == PWM_PERIOD - 8'h01) ? '0 : s_r.pos + 8'h01;
    end else begin
      s_nxt.pre = s_r.pre + 16'h0001;
    end
    s_nxt.out = i_en && (s_r.pos < i_duty);
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_pwm = s_r.out;
endmodule : dimmer_pwm
`default_nettype wire

// [src/dimmer_uart.sv]
// 8n1 serial receiver and transmitter for the console
`timescale 1ns/100ps
`default_nettype none
module dimmer_uart
  import dimmer_pkg::*;
#(
  parameter int unsigned DIV = BAUD_DIV
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_en,
  input wire logic i_rx,
  output logic o_rx_vld,
  output logic [7:0] o_rx_data,
  input wire logic i_tx_vld,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_rdy,
  output logic o_tx
);
  typedef struct packed {
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_vld;
    logic tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
  } uart_s;

  uart_s s_r;
  uart_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rx_vld = 1'b0;
    if (!s_r.rx_busy) begin
      if (!i_rx) begin
        s_nxt.rx_busy = 1'b1;
        s_nxt.rx_cnt = 16'(DIV / 2);
        s_nxt.rx_bit = '0;
      end
    end else if (s_r.rx_cnt != 16'h0000) begin
      s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
    end else begin
      s_nxt.rx_cnt = 16'(DIV - 1);
      s_nxt.rx_bit = s_r.rx_bit + 4'h1;
      // a glitch shorter than half a bit is dropped as a false start
      if (s_r.rx_bit == 4'h0 && i_rx) begin
        s_nxt.rx_busy = 1'b0;
      end else if (s_r.rx_bit == 4'h9) begin
        s_nxt.rx_busy = 1'b0;
        s_nxt.rx_vld = i_rx;
      end else if (s_r.rx_bit != 4'h0) begin
        s_nxt.rx_sh = {i_rx, s_r.rx_sh[7:1]};
      end
    end
    if (!s_r.tx_busy) begin
      if (i_tx_vld) begin
        s_nxt.tx_busy = 1'b1;
        s_nxt.tx_sh = {1'b1, i_tx_data, 1'b0};
        s_nxt.tx_cnt = 16'(DIV - 1);
        s_nxt.tx_bit = 4'ha;
      end
    end else if (s_r.tx_cnt != 16'h0000) begin
      s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
    end else begin
      s_nxt.tx_cnt = 16'(DIV - 1);
      s_nxt.tx_sh = {1'b1, s_r.tx_sh[9:1]};
      s_nxt.tx_bit = s_r.tx_bit - 4'h1;
      s_nxt.tx_busy = (s_r.tx_bit != 4'h1);
    end
    if (!i_en) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_rx_vld = s_r.rx_vld;
  assign o_rx_data = s_r.rx_sh;
  assign o_tx_rdy = i_en && !s_r.tx_busy;
  assign o_tx = s_r.tx_busy ? s_r.tx_sh[0] : 1'b1;
endmodule : dimmer_uart
`default_nettype wire

// [bench/dimmer_partner.sv]
// serial terminal and led driver model facing the dimmer
`timescale 1ns/100ps
`default_nettype none
module dimmer_partner #(
  parameter int unsigned DIV = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_pwm,
  input wire logic i_tx,
  output logic o_rx
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  initial o_rx = 1'b1;
  // 8n1 lsb first, one idle bit after the stop bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge i_mclk);
      o_rx <= (i < 10) ? fr[i] : 1'b1;
      repeat (DIV - 1) @(posedge i_mclk);
    end
  endtask : send_byte
  // sampled on the falling edge, away from the registered outputs
  initial begin
    @(negedge i_rst);
    repeat (4) @(negedge i_mclk);
    forever begin
      @(negedge i_mclk);
      if (i_tx == 1'b0) begin
        repeat (DIV / 2) @(negedge i_mclk);
        for (int i = 0; i < 8; i++) begin
          repeat (DIV) @(negedge i_mclk);
          sh[i] = i_tx;
        end
        repeat (DIV) @(negedge i_mclk);
        rx_q.push_back(sh);
      end
    end
  end
  // string current follows duty: high cycles over one pwm period
  task automatic measure(input int unsigned per, output logic [7:0] hi);
    hi = 8'h00;
    repeat (per) begin
      @(negedge i_mclk);
      hi = hi + {7'h00, i_pwm};
    end
  endtask : measure
endmodule : dimmer_partner
`default_nettype wire

// [bench/dimmer_checker.sv]
// port assertions for the motion led dimmer
`timescale 1ns/100ps
`default_nettype none
module dimmer_checker
  import dimmer_pkg::*;
#(
  parameter longint unsigned OFF_CYC = LED_OFF_CYC,
  parameter longint unsigned BLANK_CYCLES = BLANK_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_motion,
  input wire logic [3:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_port_pin_two,
  input wire logic o_port_pin_five_oe,
  input wire logic o_led_on
);
  // starts high so that reset never looks like a recent switch
  logic [63:0] since_r;
  logic [63:0] idle_r;
  logic [1:0] up_r;
  logic led_q_r;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      since_r <= 64'hffff_ffff;
      idle_r <= 64'h0;
      up_r <= 2'h0;
      led_q_r <= 1'b0;
    end else begin
      led_q_r <= o_led_on;
      since_r <= (o_led_on != led_q_r) ? 64'h0 : since_r + 64'h1;
      idle_r <= i_motion ? 64'h0 : idle_r + 64'h1;
      up_r <= (up_r == 2'h3) ? up_r : up_r + 2'h1;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence stat_rd_s;
    i_rd && i_addr == REG_STATUS ##1 $stable(o_led_on);
  endsequence
  duty_clamp_a: assert property (
    $past(i_rd) && $past(i_addr) == REG_DUTY |->
    o_rdata >= DUTY_LOWER_CLAMP && o_rdata <= DUTY_UPPER_CLAMP)
    else $error("duty read outside clamp");
  pwm_dark_a: assert property (
    !o_led_on && !$past(o_led_on) && !$past(o_led_on, 2) |-> !o_port_pin_two)
    else $error("pwm active with string off");
  motion_on_a: assert property (
    i_motion && !o_led_on && since_r > BLANK_CYCLES + 2 |=> o_led_on)
    else $error("motion did not switch string on");
  blank_hold_a: assert property (
    !o_led_on && since_r + 4 < BLANK_CYCLES |=> !o_led_on)
    else $error("motion taken while blanked");
  stay_on_a: assert property (
    o_led_on && since_r + 4 < OFF_CYC |=> o_led_on)
    else $error("string off too early");
  off_due_a: assert property (
    !(o_led_on && idle_r > OFF_CYC + 1))
    else $error("string on after timeout");
  pin_five_oe_a: assert property (
    up_r == 2'h3 |-> o_port_pin_five_oe)
    else $error("tx pin not driven");
  status_led_a: assert property (
    stat_rd_s |-> o_rdata[0] == o_led_on && o_rdata[7:3] == 5'h00)
    else $error("status led bit wrong");
  rdata_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside answer cycle");
endmodule : dimmer_checker
bind motion_led_dimmer dimmer_checker #(
  .OFF_CYC(OFF_CYC),
  .BLANK_CYCLES(BLANK_CYCLES)
) chk (
  .i_mclk(i_mclk),
  .i_rst(i_rst),
  .i_motion(i_motion),
  .i_addr(i_addr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_port_pin_two(o_port_pin_two),
  .o_port_pin_five_oe(o_port_pin_five_oe),
  .o_led_on(o_led_on)
);
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the dimmer in console mode and light mode
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dimmer_pkg::*;
  localparam longint unsigned OFF = 400;
  localparam int unsigned DIV = 8;
  localparam longint unsigned BLANK = 40;
  localparam int unsigned PRE = 1;
  logic clk = 1'b0;
  logic ce = 1'b1;
  logic pol = 1'b0;
  logic tx_oe;
  logic [7:0] rdata2;
  logic pin5_als;
  logic rst = 1'b1;
  logic motion = 1'b0;
  logic [7:0] ch1 = 8'h00;
  logic ch1_vld = 1'b0;
  logic [7:0] ch3 = 8'h00;
  logic ch3_vld = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic pwm;
  logic tx;
  logic rx;
  logic led_on;
  int num_errors = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  motion_led_dimmer #(.MODE(MODE_CONSOLE), .OFF_CYC(OFF), .BLANK_CYCLES(BLANK),
    .UART_DIV(DIV), .PWM_PRESCALE(PRE)) dut (
    .i_mclk(clk), .i_rst(rst), .i_ce(ce), .i_motion(motion),
    .i_analog_channel_one(ch1), .i_analog_channel_one_vld(ch1_vld),
    .i_analog_channel_three(ch3), .i_analog_channel_three_vld(ch3_vld),
    .i_port_pin_zero(pol), .i_port_pin_four(rx), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_port_pin_two(pwm), .o_port_pin_five(tx), .o_port_pin_five_oe(tx_oe),
    .o_led_on(led_on));
  // light build shares the stimulus; only its duty and supply pin are judged
  motion_led_dimmer #(.MODE(MODE_ALS), .OFF_CYC(OFF), .BLANK_CYCLES(BLANK),
    .UART_DIV(DIV), .PWM_PRESCALE(PRE)) dut_light (
    .i_mclk(clk), .i_rst(rst), .i_ce(ce), .i_motion(motion),
    .i_analog_channel_one(ch1), .i_analog_channel_one_vld(ch1_vld),
    .i_analog_channel_three(ch3), .i_analog_channel_three_vld(ch3_vld),
    .i_port_pin_zero(pol), .i_port_pin_four(rx), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata2),
    .o_port_pin_two(), .o_port_pin_five(pin5_als), .o_port_pin_five_oe(),
    .o_led_on());
  dimmer_partner #(.DIV(DIV)) term (.i_mclk(clk), .i_rst(rst), .i_pwm(pwm),
    .i_tx(tx), .o_rx(rx));
  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic check8(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check8
  task automatic timeout(input string what);
    num_errors++;
    $display("[ERR] %s expected done seen timeout", what);
    finish_test();
  endtask : timeout
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic rd_chk(input string what, input logic [3:0] a,
      input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check8(what, exp, rdata);
  endtask : rd_chk
  task automatic pulse_motion();
    @(posedge clk);
    motion <= 1'b1;
    @(posedge clk);
    motion <= 1'b0;
    #1;
  endtask : pulse_motion
  task automatic rx_expect(input logic [7:0] exp);
    int n = 0;
    while (term.rx_q.size() == 0) begin
      @(posedge clk);
      n++;
      if (n > 300)
        timeout("serial reply");
    end
    check8("serial byte", exp, term.rx_q.pop_front());
  endtask : rx_expect
  task automatic t_reset();
    rd_chk("status", REG_STATUS, 8'h00);
    rd_chk("duty", REG_DUTY, DUTY_LOWER_CLAMP);
    rd_chk("ctrl", REG_CTRL, 8'h00);
    rd_chk("unmapped", 4'h1, 8'h00);
    check8("tx pin enable", 8'h01, {7'h00, tx_oe});
    check8("tx pin idle", 8'h01, {7'h00, tx});
  endtask : t_reset
  task automatic t_clamp();
    logic [7:0] req [5];
    logic [7:0] exp [5];
    req = '{8'h00, 8'h0e, 8'h60, 8'hff, 8'h32};
    exp = '{8'h0f, 8'h0f, 8'h5f, 8'h5f, 8'h32};
    for (int i = 0; i < 5; i++) begin
      bus_wr(REG_DUTY, req[i]);
      rd_chk("clamped duty", REG_DUTY, exp[i]);
    end
    // a write while the clock enable is low must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    bus_wr(REG_DUTY, 8'h40);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk("frozen duty", REG_DUTY, 8'h32);
    // console build must not follow the analog inputs
    @(posedge clk);
    ch1 <= 8'hff;
    ch1_vld <= 1'b1;
    ch3 <= 8'hff;
    ch3_vld <= 1'b1;
    @(posedge clk);
    ch1_vld <= 1'b0;
    ch3_vld <= 1'b0;
    rd_chk("duty after analog", REG_DUTY, 8'h32);
  endtask : t_clamp
  task automatic t_motion();
    logic [7:0] hi;
    logic [7:0] j;
    pulse_motion();
    check8("led on", 8'h01, {7'h00, led_on});
    pulse_motion();
    repeat (5) @(posedge clk);
    term.measure(100, hi);
    check8("pwm high count", 8'h32, hi);
    pulse_motion();
    repeat (OFF - 10) @(posedge clk);
    #1;
    check8("led after restart", 8'h01, {7'h00, led_on});
    j = 8'h00;
    while (led_on) begin
      @(posedge clk);
      #1;
      j++;
      if (j > 8'h1e)
        timeout("led off");
    end
    check8("cycles to off", 8'h0a, j);
    repeat (3) @(posedge clk);
    pulse_motion();
    check8("led during blank", 8'h00, {7'h00, led_on});
    rd_chk("event count", REG_EVT_CNT, 8'h02);
  endtask : t_motion
  task automatic t_console();
    term.send_byte(CMD_DUTY);
    term.send_byte(8'h20);
    repeat (8) @(posedge clk);
    rd_chk("console duty", REG_DUTY, 8'h20);
    term.send_byte(CMD_DUTY);
    term.send_byte(DUTY_UPPER_CLAMP);
    repeat (8) @(posedge clk);
    rd_chk("console duty top", REG_DUTY, DUTY_UPPER_CLAMP);
    term.send_byte(CMD_API);
    rx_expect(DUTY_UPPER_CLAMP);
    rx_expect(8'h00);
    rx_expect(8'h02);
    term.send_byte(CMD_MENU);
    for (logic [7:0] b = 8'h01; b <= MENU_LEN; b++) begin
      rx_expect(b);
    end
    // address wraps modulo the scratch depth
    term.send_byte(CMD_WR_RAM);
    term.send_byte(8'h15);
    term.send_byte(8'ha5);
    term.send_byte(CMD_RD_RAM);
    term.send_byte(8'h05);
    rx_expect(8'ha5);
    term.send_byte(CMD_LOG_DUMP);
    rx_expect(8'h01);
    rx_expect(8'h02);
    term.send_byte(CMD_LOG_CLEAR);
    repeat (8) @(posedge clk);
    rd_chk("cleared count", REG_EVT_CNT, 8'h00);
    term.send_byte(CMD_EVT_TOGGLE);
    repeat (8) @(posedge clk);
    rd_chk("report enable", REG_CTRL, 8'h01);
    pulse_motion();
    rd_chk("status on", REG_STATUS, 8'h07);
    rx_expect(EVT_TAG);
  endtask : t_console
  // full scale light: 94 percent with pin zero low, lower clamp inverted
  task automatic t_light();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pol <= i[0];
      ch3 <= 8'hff;
      repeat (6) @(posedge clk);
      ch3_vld <= 1'b1;
      @(posedge clk);
      ch3_vld <= 1'b0;
      rd <= 1'b1;
      addr <= REG_DUTY;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check8("light duty", (i == 1) ? DUTY_LOWER_CLAMP : 8'h5e, rdata2);
    end
    check8("sensor supply", 8'h01, {7'h00, pin5_als});
  endtask : t_light
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_clamp();
    t_motion();
    t_console();
    t_light();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
